//--- iec_defines.svh
// Overview of operation
// (R1) opcode 36 clears selected error flags
// (R2) type 0 all, 1..5 single flag
// (R3) direct mode replies status 100
// (R4) opcode 25 sets one interrupt enable
// (R5) enable with 255 sets global enable
// (R6) opcode 26 clears one interrupt enable
// (R7) disable with 255 clears global enable
// (R8) opcode 37 stores handler address
// (R9) redefining a vector overwrites it
// (R10) issuer keeps vector/return in programs
// (R11) opcode 38 ends handler, resumes program
// (R12) return restores accumulator, X, flags, PC
// (R13) handlers end with return instruction
// (R14) frame: addr, opcode, type, bank, value, checksum
// (R15) clear, enable, disable accepted directly
// (R16) enabled interrupt saves context, jumps vector
// (R17) checksum is byte sum, checked first
`ifndef IEC_DEFINES_SVH
`define IEC_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes and fields
// ----------------------------------------------------------------
`define IEC_OP_IRQ_ENABLE   8'h19
`define IEC_OP_IRQ_DISABLE  8'h1A
`define IEC_OP_CLEAR_ERR    8'h24
`define IEC_OP_IRQ_VECTOR   8'h25
`define IEC_OP_IRQ_RETURN   8'h26
`define IEC_TYPE_ALL        8'h00
`define IEC_IRQ_GLOBAL      8'hFF
`define IEC_FRAME_BYTES     4'h9

// ----------------------------------------------------------------
// reply status codes
// ----------------------------------------------------------------
`define IEC_ST_OK           8'h64
`define IEC_ST_BAD_CSUM     8'h01
`define IEC_ST_BAD_CMD      8'h02

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define IEC_REG_CTRL        8'h00
`define IEC_REG_STATUS      8'h04
`define IEC_REG_MASK        8'h08
`define IEC_REG_ERRFLAGS    8'h0C
`define IEC_REG_IRQEN       8'h10
`define IEC_REG_PC          8'h14
`define IEC_CTRL_RUN        0
`define IEC_EV_CSUM         0
`define IEC_EV_IRQ_ENTER    1
`define IEC_EV_IRQ_RETURN   2
`define IEC_EV_ERR_SET      3
`define IEC_EV_BITS         4
`define IEC_IRQEN_GLOBAL    31
`define IEC_RESET_VALUE     32'h0000_0000

`endif

//--- iec_pkg.sv
package iec_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  opcode;
      logic [7:0]  ctype;
      logic [7:0]  bank;
      logic [31:0] value;
   } iec_cmd_s;

   typedef struct packed {
      logic [7:0]  hostAddr;
      logic [7:0]  modAddr;
      logic [7:0]  status;
      logic [7:0]  opcode;
      logic [31:0] value;
   } iec_reply_s;

   typedef struct packed {
      logic [31:0] acc;
      logic [31:0] xreg;
      logic [7:0]  flags;
   } iec_ctx_s;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_EXEC  = 4'b1000
   } iec_state_e;

endpackage

//--- iec_frame_rx.sv
`timescale 1ns/1ps
`include "iec_defines.svh"
module iec_frame_rx
   import iec_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // byte stream
   input  wire logic       rxValid,
   input  wire logic [7:0] rxByte,
   // assembled frame
   output iec_cmd_s        frame,
   output logic            frameValid,
   output logic            frameOk
);

   logic [3:0]  count;
   logic [7:0]  sum;
   logic [63:0] shift;
   logic [3:0]  next_count;
   logic [7:0]  next_sum;
   logic [63:0] next_shift;
   iec_cmd_s    next_frame;
   logic        next_frameValid;
   logic        next_frameOk;

   always_comb begin
      next_count      = count;
      next_sum        = sum;
      next_shift      = shift;
      next_frame      = frame;
      next_frameValid = 1'b0;
      next_frameOk    = frameOk;
      if (rxValid) begin
         if (count == `IEC_FRAME_BYTES - 4'h1) begin
            // ninth byte is the checksum over the eight before it
            next_frame      = shift; // R14
            next_frameOk    = (rxByte == sum); // R17
            next_frameValid = 1'b1;
            next_count      = 4'h0;
            next_sum        = 8'h00;
         end else begin
            next_shift = {shift[55:0], rxByte}; // R14
            next_sum   = sum + rxByte; // R17
            next_count = count + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count      <= 4'h0;
         sum        <= 8'h00;
         shift      <= '0;
         frame      <= '0;
         frameValid <= 1'b0;
         frameOk    <= 1'b0;
      end else begin
         count      <= next_count;
         sum        <= next_sum;
         shift      <= next_shift;
         frame      <= next_frame;
         frameValid <= next_frameValid;
         frameOk    <= next_frameOk;
      end
   end

endmodule

//--- iec_err_flags.sv
`timescale 1ns/1ps
module iec_err_flags
   import iec_pkg::*;
#(
   parameter int NUM_FLAGS = 5
) (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // set by motion logic, cleared by command
   input  wire logic [NUM_FLAGS-1:0] errSet,
   input  wire logic [NUM_FLAGS-1:0] errClear,
   // state
   output logic [NUM_FLAGS-1:0]      errFlags,
   output logic                      errRaised
);

   logic [NUM_FLAGS-1:0] next_errFlags;
   logic                 next_errRaised;

   genvar i;
   generate
      for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
         // a set in the clearing cycle is kept
         assign next_errFlags[i] = errSet[i] | (errFlags[i] & ~errClear[i]); // R1
      end
   endgenerate

   assign next_errRaised = |(errSet & ~errFlags);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         errFlags  <= '0;
         errRaised <= 1'b0;
      end else begin
         errFlags  <= next_errFlags;
         errRaised <= next_errRaised;
      end
   end

endmodule

//--- iec_core.sv
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`include "iec_defines.svh"
module iec_core
   import iec_pkg::*;
#(
   parameter int         NUM_IRQ   = 8,
   parameter int         PC_WIDTH  = 16,
   parameter logic [7:0] MOD_ADDR  = 8'h01,
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // direct-mode byte stream
   input  wire logic                rxValid,
   input  wire logic [7:0]          rxByte,
   // reply to host
   output iec_reply_s               reply,
   output logic                     replyValid,
   // stored program fetch
   output logic                     fetchReq,
   output logic [PC_WIDTH-1:0]      fetchAddr,
   input  wire logic                fetchValid,
   input  iec_cmd_s                 fetchCmd,
   // instructions handled elsewhere
   output iec_cmd_s                 otherCmd,
   output logic                     otherValid,
   // interrupt sources and context
   input  wire logic [NUM_IRQ-1:0]  irqSrc,
   input  iec_ctx_s                 ctxIn,
   output iec_ctx_s                 ctxOut,
   output logic                     ctxRestore,
   // error flags
   input  wire logic [4:0]          errSet,
   output logic [4:0]               errFlags,
   // register port
   input  wire logic [7:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic [31:0]              regRdata,
   output logic                     irqOut
);

   localparam int IW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

   // ----------------------------------------------------------------
   // frame receiver and error flags
   // ----------------------------------------------------------------
   iec_cmd_s   frame;
   logic       frameValid;
   logic       frameOk;
   logic [4:0] errClear;
   logic       errRaised;

   iec_frame_rx u_rx (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .rxValid    (rxValid),
      .rxByte     (rxByte),
      .frame      (frame),
      .frameValid (frameValid),
      .frameOk    (frameOk)
   );

   iec_err_flags #(.NUM_FLAGS(5)) u_flags (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .errSet    (errSet),
      .errClear  (errClear),
      .errFlags  (errFlags),
      .errRaised (errRaised)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   iec_state_e            state, next_state;
   logic [PC_WIDTH-1:0]   pc, next_pc;
   logic [PC_WIDTH-1:0]   savedPc, next_savedPc;
   iec_ctx_s              savedCtx, next_savedCtx;
   logic                  inHandler, next_inHandler;
   logic                  globalEn, next_globalEn;
   logic [NUM_IRQ-1:0]    irqEn, next_irqEn;
   logic [NUM_IRQ-1:0]    pending, next_pending;
   iec_cmd_s              heldCmd, next_heldCmd;
   iec_reply_s            next_reply;
   logic                  next_replyValid;
   logic                  next_fetchReq;
   logic [PC_WIDTH-1:0]   next_fetchAddr;
   iec_cmd_s              next_otherCmd;
   logic                  next_otherValid;
   iec_ctx_s              next_ctxOut;
   logic                  next_ctxRestore;
   logic [PC_WIDTH-1:0]   vectors [NUM_IRQ];
   logic                  vecWe;
   logic [IW-1:0]         vecIdx;
   logic [PC_WIDTH-1:0]   vecData;
   logic                  run;
   logic [`IEC_EV_BITS-1:0] events;

   // ----------------------------------------------------------------
   // command execution
   // ----------------------------------------------------------------
   iec_cmd_s      cmd;
   logic          doExec;
   logic          direct;
   logic          known;
   logic [IW-1:0] idx;
   logic          idxOk;
   logic          irqFound;
   logic [IW-1:0] irqIdx;

   always_comb begin
      next_state      = state;
      next_pc         = pc;
      next_savedPc    = savedPc;
      next_savedCtx   = savedCtx;
      next_inHandler  = inHandler;
      next_globalEn   = globalEn;
      next_irqEn      = irqEn;
      next_pending    = pending | irqSrc;
      next_heldCmd    = heldCmd;
      next_reply      = reply;
      next_replyValid = 1'b0;
      next_fetchReq   = 1'b0;
      next_fetchAddr  = fetchAddr;
      next_otherCmd   = otherCmd;
      next_otherValid = 1'b0;
      next_ctxOut     = ctxOut;
      next_ctxRestore = 1'b0;
      vecWe           = 1'b0;
      vecIdx          = '0;
      vecData         = '0;
      errClear        = '0;
      events          = '0;
      known           = 1'b0;
      irqFound        = 1'b0;
      irqIdx          = '0;
      // direct frames take priority; a fetched command waits in EXEC
      direct = frameValid && frameOk && (frame.addr == MOD_ADDR);
      doExec = direct || (state == ST_EXEC);
      cmd    = direct ? frame : heldCmd;
      idx    = cmd.ctype[IW-1:0];
      idxOk  = (cmd.ctype < 8'(NUM_IRQ));

      if (frameValid && !frameOk) begin
         events[`IEC_EV_CSUM] = 1'b1;
         next_replyValid      = 1'b1; // R17
         next_reply           = '{HOST_ADDR, MOD_ADDR, `IEC_ST_BAD_CSUM, frame.opcode, 32'h0};
      end

      if (doExec) begin
         case (cmd.opcode)
            `IEC_OP_CLEAR_ERR: begin
               known = 1'b1;
               for (int i = 0; i < 5; i++) begin
                  if (cmd.ctype == `IEC_TYPE_ALL || cmd.ctype == 8'(i + 1)) begin
                     errClear[i] = 1'b1; // R1 R2
                  end
               end
            end
            `IEC_OP_IRQ_ENABLE: begin
               known = 1'b1;
               if (cmd.ctype == `IEC_IRQ_GLOBAL) begin
                  next_globalEn = 1'b1; // R5
               end else if (idxOk) begin
                  next_irqEn[idx] = 1'b1; // R4
               end
            end
            `IEC_OP_IRQ_DISABLE: begin
               known = 1'b1;
               if (cmd.ctype == `IEC_IRQ_GLOBAL) begin
                  next_globalEn = 1'b0; // R7
               end else if (idxOk) begin
                  next_irqEn[idx] = 1'b0; // R6
               end
            end
            `IEC_OP_IRQ_VECTOR: begin
               // accepted directly too, though the issuer should not send it (R10)
               known = 1'b1;
               if (idxOk) begin
                  vecWe   = 1'b1; // R8 R9
                  vecIdx  = idx;
                  vecData = cmd.value[PC_WIDTH-1:0];
               end
            end
            `IEC_OP_IRQ_RETURN: begin
               known = 1'b1;
               // outside a handler there is nothing to restore, so it is a no-op
               if (inHandler) begin
                  next_inHandler  = 1'b0; // R11
                  next_ctxOut     = savedCtx; // R12
                  next_ctxRestore = 1'b1;
                  events[`IEC_EV_IRQ_RETURN] = 1'b1;
               end
            end
            default: begin
               known = 1'b0;
            end
         endcase

         if (direct) begin
            // direct commands answer at once, even while a program runs
            next_replyValid = 1'b1; // R3 R15
            next_reply      = '{HOST_ADDR, MOD_ADDR, known ? `IEC_ST_OK : `IEC_ST_BAD_CMD,
                                cmd.opcode, 32'h0};
            if (!known) begin
               next_otherCmd   = cmd;
               next_otherValid = 1'b1;
            end
            if (cmd.opcode == `IEC_OP_IRQ_RETURN && inHandler) begin
               next_pc = savedPc; // R12
            end
         end else begin
            if (!known) begin
               next_otherCmd   = cmd;
               next_otherValid = 1'b1;
            end
            if (cmd.opcode == `IEC_OP_IRQ_RETURN && inHandler) begin
               next_pc = savedPc; // R11 R12
            end else begin
               next_pc = pc + PC_WIDTH'(1);
            end
            next_state = run ? ST_FETCH : ST_IDLE;
         end
      end

      // lowest-numbered pending interrupt wins
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (pending[i] && irqEn[i]) begin
            irqFound = 1'b1;
            irqIdx   = IW'(i);
         end
      end

      case (state)
         ST_IDLE: begin
            if (run) begin
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (!run) begin
               next_state = ST_IDLE;
            end else if (irqFound && globalEn && !inHandler && !doExec) begin
               // taken only between instructions so the saved pc is exact
               next_savedPc         = pc; // R16
               next_savedCtx        = ctxIn;
               next_pc              = vectors[irqIdx];
               next_inHandler       = 1'b1;
               next_pending[irqIdx] = irqSrc[irqIdx];
               events[`IEC_EV_IRQ_ENTER] = 1'b1;
            end else begin
               next_fetchReq  = 1'b1;
               next_fetchAddr = pc;
               next_state     = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (fetchValid) begin
               next_heldCmd = fetchCmd;
               next_state   = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // leaving EXEC is handled by the execution block above
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // a direct frame in the EXEC cycle delays the stored command by one
      if (direct && state == ST_EXEC) begin
         next_state = ST_EXEC;
         next_pc    = (cmd.opcode == `IEC_OP_IRQ_RETURN && inHandler) ? savedPc : pc;
      end
      events[`IEC_EV_ERR_SET] = errRaised;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state      <= ST_IDLE;
         pc         <= '0;
         savedPc    <= '0;
         savedCtx   <= '0;
         inHandler  <= 1'b0;
         globalEn   <= 1'b0;
         irqEn      <= '0;
         pending    <= '0;
         heldCmd    <= '0;
         reply      <= '0;
         replyValid <= 1'b0;
         fetchReq   <= 1'b0;
         fetchAddr  <= '0;
         otherCmd   <= '0;
         otherValid <= 1'b0;
         ctxOut     <= '0;
         ctxRestore <= 1'b0;
      end else begin
         state      <= next_state;
         pc         <= next_pc;
         savedPc    <= next_savedPc;
         savedCtx   <= next_savedCtx;
         inHandler  <= next_inHandler;
         globalEn   <= next_globalEn;
         irqEn      <= next_irqEn;
         pending    <= next_pending;
         heldCmd    <= next_heldCmd;
         reply      <= next_reply;
         replyValid <= next_replyValid;
         fetchReq   <= next_fetchReq;
         fetchAddr  <= next_fetchAddr;
         otherCmd   <= next_otherCmd;
         otherValid <= next_otherValid;
         ctxOut     <= next_ctxOut;
         ctxRestore <= next_ctxRestore;
      end
   end

   // vector table has no reset; unused entries hold whatever was last written
   always_ff @(posedge sys_clk) begin
      if (vecWe) begin
         vectors[vecIdx] <= vecData; // R9
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   logic [31:0]             ctrl, next_ctrl;
   logic [`IEC_EV_BITS-1:0] status, next_status;
   logic [`IEC_EV_BITS-1:0] mask, next_mask;
   logic [31:0]             next_regRdata;
   logic                    next_irqOut;

   assign run = ctrl[`IEC_CTRL_RUN];

   always_comb begin
      next_ctrl     = ctrl;
      next_mask     = mask;
      next_status   = status;
      next_regRdata = 32'h0000_0000;
      if (regWr) begin
         case (regAddr)
            `IEC_REG_CTRL:   next_ctrl   = {31'h0, regWdata[`IEC_CTRL_RUN]};
            `IEC_REG_STATUS: next_status = status & ~regWdata[`IEC_EV_BITS-1:0];
            `IEC_REG_MASK:   next_mask   = regWdata[`IEC_EV_BITS-1:0];
            default:         next_ctrl   = ctrl;
         endcase
      end
      // new events win over a write-one clear in the same cycle
      next_status = next_status | events;
      if (regRd) begin
         case (regAddr)
            `IEC_REG_CTRL:     next_regRdata = ctrl;
            `IEC_REG_STATUS:   next_regRdata = 32'(status);
            `IEC_REG_MASK:     next_regRdata = 32'(mask);
            `IEC_REG_ERRFLAGS: next_regRdata = 32'(errFlags);
            `IEC_REG_IRQEN: begin
               next_regRdata = 32'(irqEn);
               next_regRdata[`IEC_IRQEN_GLOBAL] = globalEn;
            end
            `IEC_REG_PC:       next_regRdata = 32'(pc);
            default:           next_regRdata = 32'h0000_0000;
         endcase
      end
      next_irqOut = |(next_status & next_mask);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl     <= `IEC_RESET_VALUE;
         status   <= '0;
         mask     <= '0;
         regRdata <= `IEC_RESET_VALUE;
         irqOut   <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         status   <= next_status;
         mask     <= next_mask;
         regRdata <= next_regRdata;
         irqOut   <= next_irqOut;
      end
   end

endmodule

//--- iec_core_monitor.sv
`timescale 1ns/1ps
module iec_core_monitor
   import iec_pkg::*;
#(
   parameter logic [7:0] MOD_ADDR  = 8'h01,
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // watched outputs and causes
   input iec_reply_s      reply,
   input wire logic       replyValid,
   input wire logic       fetchReq,
   input wire logic       ctxRestore,
   input wire logic [4:0] errSet,
   input wire logic [4:0] errFlags
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_reply_fields: assert property (replyValid |-> reply.hostAddr == HOST_ADDR
      && reply.modAddr == MOD_ADDR && reply.value == 32'h0000_0000)
      else $error("bad reply fields");
   a_ok_known_ops: assert property (replyValid && reply.status == 8'h64
      |-> reply.opcode inside {8'h19, 8'h1A, 8'h24, 8'h25, 8'h26})
      else $error("ok status for an unhandled opcode");
   a_known_op_status: assert property (replyValid
      && reply.opcode inside {8'h19, 8'h1A, 8'h24, 8'h25, 8'h26}
      |-> reply.status inside {8'h64, 8'h01})
      else $error("bad status for a handled opcode");
   a_err_set_wins: assert property (|errSet
      |=> (($past(errSet) & ~errFlags) == 5'h00))
      else $error("error flag not set by its source");
   a_err_clear_cause: assert property ((|($past(errFlags) & ~errFlags))
      |-> !(replyValid && reply.opcode != 8'h24))
      else $error("error flag dropped by another command");
   a_fetch_pulse: assert property (fetchReq |=> !fetchReq)
      else $error("fetch request longer than one cycle");
   a_restore_pulse: assert property (ctxRestore |=> !ctxRestore)
      else $error("context restore too long");
   a_reply_spacing: assert property (replyValid |=> !replyValid [*8])
      else $error("replies closer than one frame");
endmodule

bind iec_core iec_core_monitor #(.MOD_ADDR(MOD_ADDR), .HOST_ADDR(HOST_ADDR)) mon_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .reply(reply), .replyValid(replyValid),
   .fetchReq(fetchReq), .ctxRestore(ctxRestore), .errSet(errSet), .errFlags(errFlags));

//--- iec_prog_model.sv
`timescale 1ns/1ps
module iec_prog_model
   import iec_pkg::*;
#(
   parameter int PC_WIDTH = 16,
   parameter int LAT      = 2
) (
   // clock and reset
   input wire logic                sys_clk,
   input wire logic                rst_n,
   // program fetch port
   input wire logic                fetchReq,
   input wire logic [PC_WIDTH-1:0] fetchAddr,
   input wire logic                slow,
   output logic                    fetchValid,
   output iec_cmd_s                fetchCmd
);
   iec_cmd_s                mem [0:63];
   logic     [PC_WIDTH-1:0] addr;
   int                      waitN;

   always_ff @(posedge sys_clk) begin
      fetchValid <= 1'b0;
      // outside the answer cycle the word is not held, so stale data cannot pass
      fetchCmd <= ~fetchCmd;
      if (!rst_n) begin
         waitN <= 0;
         fetchCmd <= '0;
      end else if (fetchReq) begin
         addr <= fetchAddr;
         waitN <= slow ? LAT + 4 : LAT;
      end else if (waitN == 1) begin
         fetchValid <= 1'b1;
         fetchCmd <= mem[addr[5:0]];
         waitN <= 0;
      end else if (waitN > 1) begin
         waitN <= waitN - 1;
      end
   end
endmodule

//--- test_iec_core.sv
`timescale 1ns/1ps
`include "iec_defines.svh"
module test_iec_core;
   import iec_pkg::*;
   localparam logic [7:0] MA = 8'h01;
   logic sys_clk = 1'b0, rst_n = 1'b0, rxValid = 1'b0, regWr = 1'b0, regRd = 1'b0, slow = 1'b0;
   logic [7:0] rxByte = 8'h00, regAddr = 8'h00, irqSrc = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000, regRdata, d;
   logic [4:0] errSet = 5'h00, errFlags;
   logic [15:0] fetchAddr, last = 16'h0006;
   logic replyValid, fetchReq, fetchValid, otherValid, ctxRestore, irqOut, hit;
   iec_reply_s reply;
   iec_cmd_s fetchCmd, otherCmd;
   iec_ctx_s ctxIn = 72'h1111_2222_3333_4444_55, ctxOut;
   int fails = 0, cmpCount = 0, cycles = 0, k;

   always #2.5 sys_clk = ~sys_clk;

   iec_core #(.MOD_ADDR(MA)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .rxValid(rxValid),
      .rxByte(rxByte), .reply(reply), .replyValid(replyValid), .fetchReq(fetchReq),
      .fetchAddr(fetchAddr), .fetchValid(fetchValid), .fetchCmd(fetchCmd),
      .otherCmd(otherCmd), .otherValid(otherValid), .irqSrc(irqSrc), .ctxIn(ctxIn),
      .ctxOut(ctxOut), .ctxRestore(ctxRestore), .errSet(errSet), .errFlags(errFlags),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irqOut(irqOut));
   iec_prog_model prog_u (.sys_clk(sys_clk), .rst_n(rst_n), .fetchReq(fetchReq),
      .fetchAddr(fetchAddr), .slow(slow), .fetchValid(fetchValid), .fetchCmd(fetchCmd));

   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic testDone();
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk) {regWr, regAddr, regWdata} <= {1'b1, a, v};
      @(posedge sys_clk) regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk) {regRd, regAddr} <= {1'b1, a};
      @(posedge sys_clk) regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // one frame; reply two edges after the last byte
   task automatic send(input logic [7:0] op, ty, input logic [31:0] v, input logic bad);
      logic [7:0] b [9];
      logic [7:0] s;
      b = '{MA, op, ty, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      s = 8'h00;
      for (int n = 0; n < 8; n++) s = s + b[n];
      b[8] = bad ? ~s : s;
      for (int n = 0; n < 9; n++) @(posedge sys_clk) {rxValid, rxByte} <= {1'b1, b[n]};
      @(posedge sys_clk) rxValid <= 1'b0;
      @(posedge sys_clk) #1 chk(replyValid, 1'b1);
      chk(reply.status, bad ? 8'h01 :
         op inside {8'h19, 8'h1A, [8'h24:8'h26]} ? 8'h64 : 8'h02);
      chk(otherValid, !bad && !(op inside {8'h19, 8'h1A, [8'h24:8'h26]}));
      chk(reply.opcode, op);
   endtask
   task automatic pulseErr(input logic [4:0] e);
      @(posedge sys_clk) errSet <= e;
      @(posedge sys_clk) errSet <= 5'h00;
   endtask

   task automatic tRegs();
      rd(8'hFC); chk(d, 32'h0000_0000);
      send(8'h05, 8'h00, 32'h0000_0000, 1'b0);
      wr(`IEC_REG_PC, 32'h0000_1234); rd(`IEC_REG_PC); chk(d, 32'h0000_0000);
      wr(`IEC_REG_ERRFLAGS, 32'h0000_001F); chk(errFlags, 5'h00);
      $display("test registers done");
   endtask
   task automatic tClear();
      for (k = 1; k <= 5; k++) begin
         pulseErr(5'h1F);
         send(8'h24, k[7:0], 32'hFFFF_FFFF, 1'b0);
         chk(errFlags, 5'h1F & ~(5'h01 << (k - 1)));
      end
      send(8'h24, 8'h00, 32'h0000_0000, 1'b0); chk(errFlags, 5'h00);
      $display("test clear flags done");
   endtask
   task automatic tCsum();
      wr(`IEC_REG_MASK, 32'h0000_0001);
      pulseErr(5'h10);
      send(8'h24, 8'h00, 32'h0000_0000, 1'b1); chk(errFlags, 5'h10);
      #10 chk(irqOut, 1'b1);
      rd(`IEC_REG_STATUS); chk(d[0], 1'b1);
      wr(`IEC_REG_STATUS, 32'h0000_0001);
      #11 chk(irqOut, 1'b0);
      send(8'h24, 8'h00, 32'h0000_0000, 1'b0); chk(errFlags, 5'h00);
      $display("test checksum done");
   endtask
   task automatic tEnable();
      send(8'h19, 8'h03, 32'h0000_0000, 1'b0); send(8'h19, 8'hFF, 32'h0000_0000, 1'b0);
      rd(`IEC_REG_IRQEN); chk(d, 32'h8000_0008);
      send(8'h1A, 8'h03, 32'h0000_0000, 1'b0);
      rd(`IEC_REG_IRQEN); chk(d, 32'h8000_0000);
      send(8'h1A, 8'hFF, 32'h0000_0000, 1'b0);
      rd(`IEC_REG_IRQEN); chk(d, 32'h0000_0000);
      $display("test enables done");
   endtask
   task automatic tProg();
      // handler sits apart, ends in a return; vectors set only here
      for (k = 0; k < 64; k++) prog_u.mem[k] = {MA, 8'h05, 16'h0000, 32'h0000_0000};
      prog_u.mem[0] = {MA, 8'h25, 16'h0000, 32'h0000_0009};
      prog_u.mem[1] = {MA, 8'h25, 16'h0000, 32'h0000_000C};
      prog_u.mem[2] = {MA, 8'h19, 16'h0000, 32'h0000_0000};
      prog_u.mem[3] = {MA, 8'h19, 16'hFF00, 32'h0000_0000};
      prog_u.mem[12] = {MA, 8'h26, 16'hFF00, 32'h0000_0000};
      slow <= 1'b1;
      wr(`IEC_REG_MASK, 32'h0000_0006);
      wr(`IEC_REG_CTRL, 32'h0000_0001);
      for (k = 0; k < 200 && !(fetchReq && fetchAddr == 16'h0006); k++) @(posedge sys_clk) #1;
      @(posedge sys_clk) irqSrc <= 8'h01;
      @(posedge sys_clk) irqSrc <= 8'h00;
      hit = 1'b0;
      for (k = 0; k < 60 && !hit; k++) begin
         @(posedge sys_clk) #1;
         if (fetchReq && fetchAddr == 16'h000C) hit = 1'b1;
         else if (fetchReq) last = fetchAddr;
      end
      chk(hit, 1'b1);
      chk(irqOut, 1'b1);
      for (k = 0; k < 60 && ctxRestore !== 1'b1; k++) @(posedge sys_clk) #1;
      chk(ctxOut, ctxIn);
      for (k = 0; k < 60 && fetchReq !== 1'b1; k++) @(posedge sys_clk) #1;
      chk(fetchAddr, last + 16'h0001);
      wr(`IEC_REG_CTRL, 32'h0000_0000);
      rd(`IEC_REG_STATUS); chk(d[2:1], 2'b11);
      $display("test interrupt program done");
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         testDone();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      tRegs();
      tClear();
      tCsum();
      tEnable();
      tProg();
      testDone();
   end
endmodule
